// File: core/evt_if.sv
// carrier between the counter core and its pin edge detector
`timescale 1ns/10ps
interface evt_if;
  logic [1:0] edge_sel;
  logic run;
  logic valid_edge;
  modport det (input edge_sel, input run, output valid_edge);
  modport core (output edge_sel, output run, input valid_edge);
endinterface

// File: core/pin_edge_detect.sv
// synchroniser and valid-edge detector for the event input pin
`timescale 1ns/10ps
module pin_edge_detect (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // event pin from outside
  input wire logic pin,
  // link to the counter core
  evt_if.det ev
);

  tmr_pkg::det_state_type s_q;
  tmr_pkg::det_state_type s_d;
  logic rise;
  logic fall;

  // edge decode from the second stage against its delayed copy
  assign rise = s_q.sync & ~s_q.prev;
  assign fall = ~s_q.sync & s_q.prev;

  // next state: two-stage sync, then one-cycle valid-edge pulse
  always_comb begin
    s_d = s_q;
    s_d.meta = pin;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
    s_d.hit = 1'b0;
    if (ev.run) begin
      case (ev.edge_sel)
        tmr_pkg::EDGE_FALL: s_d.hit = fall;
        tmr_pkg::EDGE_RISE: s_d.hit = rise;
        tmr_pkg::EDGE_BOTH: s_d.hit = rise | fall;
        default: s_d.hit = 1'b0; // prohibited code: no edges
      endcase
    end
  end

  // state register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ev.valid_edge = s_q.hit;

endmodule // pin_edge_detect

// File: core/timer_event_counter_16bit.sv
// 16-bit timer/event counter with compare, capture/compare and overflow
//
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps

module timer_event_counter_16bit (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // register port
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [15:0] rdata,
  // event pin
  input wire logic event_input_pin,
  // match interrupts
  output logic match_a_irq,
  output logic match_b_irq
);

  // ---------------------------------------------------------------
  // state and internal signals
  // ---------------------------------------------------------------
  tmr_pkg::core_state_type s_q;
  tmr_pkg::core_state_type s_d;
  logic running;
  logic tick;
  logic hit_a;
  logic hit_b;
  logic zero_guard;
  logic edge_clr;
  logic wrap;
  logic [7:0] mode_byte;
  logic [7:0] presc_byte;
  logic [7:0] ccctl_byte;

  evt_if ev ();

  // pin synchroniser and edge detector
  pin_edge_detect u_det (
    .mclk(mclk),
    .reset_n(reset_n),
    .pin(event_input_pin),
    .ev(ev.det)
  );

  assign ev.edge_sel = s_q.edge_sel;
  assign ev.run = running;

  // ---------------------------------------------------------------
  // count clock, match and clear decode
  // ---------------------------------------------------------------
  assign running = (s_q.run != tmr_pkg::RUN_STOP);

  // count enable: prescaled mclk or pin edge, gated off when stopped
  always_comb begin
    tick = 1'b0;
    if (running) begin
      case (s_q.clk_sel)
        tmr_pkg::CSEL_DIV1: tick = 1'b1;
        tmr_pkg::CSEL_DIV2: tick = s_q.div[0];
        tmr_pkg::CSEL_DIV4: tick = (s_q.div == tmr_pkg::DIV_LAST);
        tmr_pkg::CSEL_PIN: tick = ev.valid_edge;
        default: tick = 1'b0;
      endcase
    end
  end

  // a zero compare value stays quiet until the first clear or wrap after start
  assign zero_guard = (s_q.count == tmr_pkg::COUNT_RESET) && s_q.fresh;
  assign hit_a = (s_q.count == s_q.cmp_a) && !zero_guard;
  assign hit_b = (s_q.count == s_q.ccb) && !zero_guard && !s_q.cb_cap;
  assign edge_clr = (s_q.run == tmr_pkg::RUN_EDGE_CLR) && ev.valid_edge;
  assign wrap = tick && !edge_clr && (s_q.count == tmr_pkg::COUNT_MAX);

  // ---------------------------------------------------------------
  // register views
  // ---------------------------------------------------------------
  // mode byte: unused bits read as zero
  always_comb begin
    mode_byte = tmr_pkg::BYTE_RESET;
    mode_byte[tmr_pkg::RUN_HI_BIT] = s_q.run[1];
    mode_byte[tmr_pkg::RUN_LO_BIT] = s_q.run[0];
    mode_byte[tmr_pkg::OVF_BIT] = s_q.ovf;
  end

  // prescaler byte: edge select and count clock select
  always_comb begin
    presc_byte = tmr_pkg::BYTE_RESET;
    presc_byte[tmr_pkg::EDGE_HI_BIT] = s_q.edge_sel[1];
    presc_byte[tmr_pkg::EDGE_LO_BIT] = s_q.edge_sel[0];
    presc_byte[tmr_pkg::CSEL_HI_BIT] = s_q.clk_sel[1];
    presc_byte[tmr_pkg::CSEL_LO_BIT] = s_q.clk_sel[0];
  end

  // capture/compare control byte
  always_comb begin
    ccctl_byte = tmr_pkg::BYTE_RESET;
    ccctl_byte[tmr_pkg::CB_CAP_BIT] = s_q.cb_cap;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.div = s_q.div + 2'h1;
    s_d.irq_a = tick && hit_a;
    s_d.irq_b = tick && hit_b;
    s_d.rdata = 16'h0000;

    // counter: stop clears, edge or match clears, else step
    if (!running) begin
      s_d.count = tmr_pkg::COUNT_RESET;
      s_d.fresh = 1'b1;
    end else if (edge_clr) begin
      s_d.count = tmr_pkg::COUNT_RESET;
      s_d.fresh = 1'b0;
    end else if (tick) begin
      if ((s_q.run == tmr_pkg::RUN_MATCH_CLR) && hit_a) begin
        s_d.count = tmr_pkg::COUNT_RESET;
        s_d.fresh = 1'b0;
      end else begin
        s_d.count = s_q.count + 16'h0001;
        if (wrap) begin
          s_d.fresh = 1'b0;
        end
      end
    end

    // capture only in capture mode; a read of the count never captures
    if (running && s_q.cb_cap && ev.valid_edge) begin
      s_d.ccb = s_q.count;
    end

    // register writes, whole units; bit writes come as read-modify-write
    if (wr_stb) begin
      case (addr)
        tmr_pkg::ADDR_CMP_A: s_d.cmp_a = wdata;
        tmr_pkg::ADDR_CCB: s_d.ccb = wdata;
        tmr_pkg::ADDR_MODE: begin
          s_d.run = {wdata[tmr_pkg::RUN_HI_BIT], wdata[tmr_pkg::RUN_LO_BIT]};
          s_d.ovf = wdata[tmr_pkg::OVF_BIT];
        end
        tmr_pkg::ADDR_PRESC: begin
          s_d.edge_sel = {wdata[tmr_pkg::EDGE_HI_BIT], wdata[tmr_pkg::EDGE_LO_BIT]};
          s_d.clk_sel = {wdata[tmr_pkg::CSEL_HI_BIT], wdata[tmr_pkg::CSEL_LO_BIT]};
        end
        tmr_pkg::ADDR_CCCTL: s_d.cb_cap = wdata[tmr_pkg::CB_CAP_BIT];
        default: s_d.run = s_q.run; // unmapped: ignored
      endcase
    end

    // stopping clears the flag, even when a wrap comes in the same cycle
    if (running && (s_d.run == tmr_pkg::RUN_STOP)) begin
      s_d.ovf = 1'b0;
    end else if (wrap) begin
      s_d.ovf = 1'b1;
    end

    // read data for the cycle after the strobe
    if (rd_stb) begin
      case (addr)
        tmr_pkg::ADDR_COUNT: s_d.rdata = running ? s_q.count : tmr_pkg::COUNT_RESET;
        tmr_pkg::ADDR_CMP_A: s_d.rdata = s_q.cmp_a;
        tmr_pkg::ADDR_CCB: s_d.rdata = s_q.ccb;
        tmr_pkg::ADDR_MODE: s_d.rdata = {8'h00, mode_byte};
        tmr_pkg::ADDR_PRESC: s_d.rdata = {8'h00, presc_byte};
        tmr_pkg::ADDR_CCCTL: s_d.rdata = {8'h00, ccctl_byte};
        default: s_d.rdata = 16'h0000;
      endcase
    end
  end

  // state register; everything resets to zero
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flip-flops
  assign rdata = s_q.rdata;
  assign match_a_irq = s_q.irq_a;
  assign match_b_irq = s_q.irq_b;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  stop_clears_count_a: assert property (!running |=> s_q.count == 16'h0000)
    else $error("count not cleared while stopped");

  stopped_read_zero_a: assert property (
    rd_stb && addr == tmr_pkg::ADDR_COUNT && !running |=> rdata == 16'h0000)
    else $error("count read not zero while stopped");

  live_read_count_a: assert property (
    rd_stb && addr == tmr_pkg::ADDR_COUNT && running |=> rdata == $past(s_q.count))
    else $error("count read not the live value");

  count_steps_a: assert property (
    tick && s_q.run == tmr_pkg::RUN_FREE && s_q.count != 16'hffff
    |=> s_q.count == $past(s_q.count) + 16'h0001)
    else $error("count did not step by one");

  div4_rate_a: assert property (
    running && s_q.clk_sel == tmr_pkg::CSEL_DIV4 && tick
    ##1 (running && s_q.clk_sel == tmr_pkg::CSEL_DIV4) [*3] |-> !tick)
    else $error("divide-by-four tick came early");

  wrap_sets_ovf_a: assert property (
    wrap && !wr_stb |=> s_q.ovf && s_q.count == 16'h0000)
    else $error("wrap did not set overflow");

  stop_clears_ovf_a: assert property (
    running && wr_stb && addr == tmr_pkg::ADDR_MODE && wdata[3:2] == 2'h0
    |=> !s_q.ovf ##1 s_q.count == 16'h0000)
    else $error("stop did not clear overflow and count");

  edge_clears_a: assert property (edge_clr |=> s_q.count == 16'h0000)
    else $error("edge did not clear count");

  match_clears_a: assert property (
    tick && s_q.run == tmr_pkg::RUN_MATCH_CLR && hit_a && !edge_clr
    |=> s_q.count == 16'h0000 && match_a_irq)
    else $error("match did not clear count");

  match_a_irq_a: assert property (
    match_a_irq |-> $past(tick) && $past(s_q.count) == $past(s_q.cmp_a))
    else $error("irq a without a match");

  match_b_irq_a: assert property (
    match_b_irq |-> !$past(s_q.cb_cap) && $past(s_q.count) == $past(s_q.ccb))
    else $error("irq b without a compare match");

  compare_holds_b_a: assert property (
    !s_q.cb_cap && !(wr_stb && addr == tmr_pkg::ADDR_CCB) |=> $stable(s_q.ccb))
    else $error("register b changed in compare mode");

  capture_loads_a: assert property (
    running && s_q.cb_cap && ev.valid_edge && !wr_stb |=> s_q.ccb == $past(s_q.count))
    else $error("capture did not load the count");

  read_no_capture_a: assert property (
    rd_stb && !wr_stb && !ev.valid_edge |=> $stable(s_q.ccb))
    else $error("read changed register b");

  zero_start_quiet_a: assert property (
    $rose(running) && s_q.cmp_a == 16'h0000 |-> ##1 !match_a_irq [*2])
    else $error("zero compare matched right after start");

  mode_reserved_a: assert property (
    rd_stb && addr == tmr_pkg::ADDR_MODE |=> rdata[15:4] == 12'h000 && !rdata[1])
    else $error("reserved mode bits not zero");

  // ---------------------------------------------------------------
  // assertions on count clock selection, the pin path and count writes
  // ---------------------------------------------------------------
  div2_rate_a: assert property (
    running && s_q.clk_sel == tmr_pkg::CSEL_DIV2 && tick
    ##1 (running && s_q.clk_sel == tmr_pkg::CSEL_DIV2) |-> !tick)
    else $error("divide-by-two tick came early");

  pin_count_holds_a: assert property (
    s_q.run == tmr_pkg::RUN_FREE && s_q.clk_sel == tmr_pkg::CSEL_PIN && !ev.valid_edge
    |=> $stable(s_q.count))
    else $error("count moved without a pin edge");

  count_write_ignored_a: assert property (
    wr_stb && addr == tmr_pkg::ADDR_COUNT && s_q.run == tmr_pkg::RUN_FREE && !tick |=> $stable(s_q.count))
    else $error("write to the count changed it");

  edge_needs_run_a: assert property (ev.valid_edge |-> $past(running))
    else $error("pin edge seen while stopped");

  no_edge_code_a: assert property (
    s_q.edge_sel == 2'h2 && $past(s_q.edge_sel) == 2'h2 |-> !ev.valid_edge)
    else $error("edge reported for the prohibited code");

  // ---------------------------------------------------------------
  // assertions on registers and flags
  // ---------------------------------------------------------------
  cmp_a_holds_a: assert property (
    !(wr_stb && addr == tmr_pkg::ADDR_CMP_A) |=> $stable(s_q.cmp_a))
    else $error("compare a changed without a write");

  run_follows_write_a: assert property (
    wr_stb && addr == tmr_pkg::ADDR_MODE
    |=> s_q.run == $past({wdata[tmr_pkg::RUN_HI_BIT], wdata[tmr_pkg::RUN_LO_BIT]}))
    else $error("run field did not follow the byte write");

  ovf_sw_set_a: assert property (
    wr_stb && addr == tmr_pkg::ADDR_MODE && wdata[tmr_pkg::OVF_BIT] && !running |=> s_q.ovf)
    else $error("software could not set overflow");

  ovf_sw_clear_a: assert property (
    wr_stb && addr == tmr_pkg::ADDR_MODE && !wdata[tmr_pkg::OVF_BIT] && !wrap |=> !s_q.ovf)
    else $error("software could not clear overflow");

  capture_quiet_b_a: assert property (s_q.cb_cap |=> !match_b_irq)
    else $error("irq b while in capture mode");

  ctl_reserved_a: assert property (
    rd_stb && addr == tmr_pkg::ADDR_CCCTL |=> rdata[15:3] == 13'h0000 && rdata[1:0] == 2'h0)
    else $error("reserved control bits not zero");

  // main scenarios reached
  cover_wrap_c: cover property (wrap ##1 s_q.ovf);
  cover_capture_c: cover property (running && s_q.cb_cap && ev.valid_edge);
  cover_edge_clear_c: cover property (edge_clr ##1 s_q.count == 16'h0000);
  cover_match_clear_c: cover property (s_q.run == tmr_pkg::RUN_MATCH_CLR && match_a_irq);
  cover_zero_first_c: cover property (s_q.cmp_a == 16'h0000 && match_a_irq);

endmodule // timer_event_counter_16bit

// File: core/tmr_pkg.sv
// constants and state types for the 16-bit timer/event counter
package tmr_pkg;

  // ---------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------
  localparam logic [15:0] ADDR_COUNT = 16'hff10;
  localparam logic [15:0] ADDR_CMP_A = 16'hff12;
  localparam logic [15:0] ADDR_CCB = 16'hff14;
  localparam logic [15:0] ADDR_MODE = 16'hffba;
  localparam logic [15:0] ADDR_PRESC = 16'hffbb;
  localparam logic [15:0] ADDR_CCCTL = 16'hffbc;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int RUN_HI_BIT = 3;
  localparam int RUN_LO_BIT = 2;
  localparam int OVF_BIT = 0;
  localparam int CB_CAP_BIT = 2;
  localparam int EDGE_HI_BIT = 5;
  localparam int EDGE_LO_BIT = 4;
  localparam int CSEL_HI_BIT = 1;
  localparam int CSEL_LO_BIT = 0;

  // ---------------------------------------------------------------
  // reset values and special counts
  // ---------------------------------------------------------------
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [1:0] DIV_LAST = 2'h3;

  // ---------------------------------------------------------------
  // run modes, edge codes, count clock selections
  // ---------------------------------------------------------------
  localparam logic [1:0] RUN_STOP = 2'h0;
  localparam logic [1:0] RUN_FREE = 2'h1;
  localparam logic [1:0] RUN_EDGE_CLR = 2'h2;
  localparam logic [1:0] RUN_MATCH_CLR = 2'h3;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [1:0] CSEL_DIV1 = 2'h0;
  localparam logic [1:0] CSEL_DIV2 = 2'h1;
  localparam logic [1:0] CSEL_DIV4 = 2'h2;
  localparam logic [1:0] CSEL_PIN = 2'h3;

  // ---------------------------------------------------------------
  // state of the counter core
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] cmp_a;
    logic [15:0] ccb;
    logic [1:0] run;
    logic ovf;
    logic cb_cap;
    logic [1:0] edge_sel;
    logic [1:0] clk_sel;
    logic [1:0] div;
    logic fresh;
    logic irq_a;
    logic irq_b;
    logic [15:0] rdata;
  } core_state_type;

  // state of the pin edge detector
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic hit;
  } det_state_type;

endpackage

// File: verif/pin_driver.sv
// model of the outside signal source on the event input pin
`timescale 1ns/10ps
module pin_driver (
  // clock
  input wire logic mclk,
  // event pin towards the timer
  output logic pin
);
  // ---------------------------------------------------------------
  // level driver
  // ---------------------------------------------------------------
  // pin idles low so that a run start never sees a false rising edge
  initial begin
    pin = 1'b0;
  end

  // change the level just after an edge, then hold it well past the sync delay
  task drive(input logic level);
    @(posedge mclk);
    pin <= level;
    repeat (6) @(posedge mclk);
  endtask
endmodule // pin_driver

// File: verif/timer_event_counter_16bit_bench.sv
// self-checking bench for the 16-bit timer/event counter
`timescale 1ns/10ps
module timer_event_counter_16bit_bench;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic mclk;
  logic reset_n;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic wr_stb;
  logic rd_stb;
  logic [15:0] rdata;
  logic event_input_pin;
  logic match_a_irq;
  logic match_b_irq;
  int fail_count;
  int tests_run;
  int n;
  logic [15:0] v;
  logic [15:0] c1;
  logic [15:0] regs [7];

  // ---------------------------------------------------------------
  // design and pin source
  // ---------------------------------------------------------------
  timer_event_counter_16bit timer_event_counter_16bit_inst (
    .mclk(mclk),
    .reset_n(reset_n),
    .addr(addr),
    .wdata(wdata),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .rdata(rdata),
    .event_input_pin(event_input_pin),
    .match_a_irq(match_a_irq),
    .match_b_irq(match_b_irq)
  );

  pin_driver pin_driver_inst (
    .mclk(mclk),
    .pin(event_input_pin)
  );

  // ---------------------------------------------------------------
  // clock, tasks
  // ---------------------------------------------------------------
  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // compare and count
  task check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle register write
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask

  // one-cycle register read, data taken in the following cycle
  task rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1;
    d = rdata;
  endtask

  // wait for a match pulse (0: a, 1: b), giving up after limit cycles
  task wait_irq(input int which, input int limit, output int cyc);
    cyc = 0;
    do begin
      @(posedge mclk);
      #1;
      cyc++;
    end while (!((which == 0) ? match_a_irq === 1'b1 : match_b_irq === 1'b1) && cyc < limit);
  endtask

  // verdict and end of run
  task finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // watchdog against a hang: the wrap scenario alone needs about 66000 cycles
  initial begin
    repeat (90000) @(posedge mclk);
    fail_count++;
    finish_test;
  end

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    fail_count = 0;
    tests_run = 0;
    reset_n = 1'b0;
    addr = 16'h0000;
    wdata = 16'h0000;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    regs = '{tmr_pkg::ADDR_CMP_A, tmr_pkg::ADDR_CCB, tmr_pkg::ADDR_MODE, tmr_pkg::ADDR_COUNT,
             tmr_pkg::ADDR_PRESC, tmr_pkg::ADDR_CCCTL, 16'hff20};
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    // reset values, unmapped place ignores writes
    wr(16'hff20, 16'h5a5a);
    foreach (regs[i]) begin
      rd(regs[i], v);
      check(v, 16'h0000);
    end
    // free run: count steps each cycle, both compares fire
    wr(tmr_pkg::ADDR_CMP_A, 16'h0020);
    wr(tmr_pkg::ADDR_CCB, 16'h0010);
    wr(tmr_pkg::ADDR_MODE, 16'h0004);
    rd(tmr_pkg::ADDR_COUNT, v);
    rd(tmr_pkg::ADDR_COUNT, c1);
    check(c1 - v, 16'h0002);
    wait_irq(1, 40, n);
    check(16'(n < 40), 16'h0001);
    wait_irq(0, 40, n);
    check(16'(n < 40), 16'h0001);
    wr(tmr_pkg::ADDR_MODE, 16'h0000);
    rd(tmr_pkg::ADDR_COUNT, v);
    check(v, 16'h0000);
    rd(tmr_pkg::ADDR_CMP_A, v);
    check(v, 16'h0020);
    // clear and start on match: period is compare plus one
    wr(tmr_pkg::ADDR_CMP_A, 16'h0003);
    wr(tmr_pkg::ADDR_MODE, 16'h000c);
    wait_irq(0, 40, n);
    wait_irq(0, 40, n);
    check(16'(n), 16'h0004);
    // reset in mid-run clears count, compares and mode
    reset_n <= 1'b0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    rd(tmr_pkg::ADDR_CMP_A, v);
    check(v, 16'h0000);
    rd(tmr_pkg::ADDR_CCB, v);
    check(v, 16'h0000);
    rd(tmr_pkg::ADDR_MODE, v);
    check(v, 16'h0000);
    // capture on each edge code, including the prohibited one
    for (int i = 0; i < 4; i++) begin
      wr(tmr_pkg::ADDR_CCB, 16'h0000);
      wr(tmr_pkg::ADDR_CCCTL, 16'h0004);
      wr(tmr_pkg::ADDR_PRESC, {10'h000, 2'(i), 4'h0});
      wr(tmr_pkg::ADDR_MODE, 16'h0004);
      repeat (8) @(posedge mclk);
      pin_driver_inst.drive(1'b1);
      rd(tmr_pkg::ADDR_CCB, v);
      check(16'(v != 16'h0000), 16'(i[0]));
      pin_driver_inst.drive(1'b0);
      rd(tmr_pkg::ADDR_CCB, c1);
      check(16'(c1 != v), 16'(i == 0 || i == 3));
      rd(tmr_pkg::ADDR_COUNT, v);
      rd(tmr_pkg::ADDR_CCB, v);
      check(v, c1);
      wr(tmr_pkg::ADDR_MODE, 16'h0000);
    end
    // compare mode ignores the pin
    wr(tmr_pkg::ADDR_CCB, 16'h7777);
    wr(tmr_pkg::ADDR_CCCTL, 16'h0000);
    wr(tmr_pkg::ADDR_PRESC, 16'h0010);
    wr(tmr_pkg::ADDR_MODE, 16'h0004);
    pin_driver_inst.drive(1'b1);
    rd(tmr_pkg::ADDR_CCB, v);
    check(v, 16'h7777);
    pin_driver_inst.drive(1'b0);
    wr(tmr_pkg::ADDR_MODE, 16'h0000);
    // clear and start on pin edge
    wr(tmr_pkg::ADDR_MODE, 16'h0008);
    repeat (40) @(posedge mclk);
    pin_driver_inst.drive(1'b1);
    rd(tmr_pkg::ADDR_COUNT, v);
    check(16'(v < 16'h0010), 16'h0001);
    pin_driver_inst.drive(1'b0);
    wr(tmr_pkg::ADDR_MODE, 16'h0000);
    // count clock rates: mclk, half and quarter over an eight-cycle span
    for (int i = 0; i < 3; i++) begin
      wr(tmr_pkg::ADDR_PRESC, 16'(i));
      wr(tmr_pkg::ADDR_MODE, 16'h0004);
      rd(tmr_pkg::ADDR_COUNT, v);
      repeat (6) @(posedge mclk);
      rd(tmr_pkg::ADDR_COUNT, c1);
      check(c1 - v, 16'h0008 >> i);
      wr(tmr_pkg::ADDR_MODE, 16'h0000);
    end
    // pin rising edges as count clock, register b left unused; count writes ignored
    wr(tmr_pkg::ADDR_PRESC, 16'h0013);
    wr(tmr_pkg::ADDR_MODE, 16'h0004);
    wr(tmr_pkg::ADDR_COUNT, 16'h1234);
    repeat (2) begin
      pin_driver_inst.drive(1'b1);
      pin_driver_inst.drive(1'b0);
    end
    rd(tmr_pkg::ADDR_COUNT, v);
    check(v, 16'h0002);
    wr(tmr_pkg::ADDR_MODE, 16'h0000);
    wr(tmr_pkg::ADDR_PRESC, 16'h0000);
    // zero compare: no match at start, first match after the wrap
    wr(tmr_pkg::ADDR_CMP_A, 16'h0000);
    wr(tmr_pkg::ADDR_MODE, 16'h0004);
    wait_irq(0, 200, n);
    check(16'(n), 16'h00c8);
    wait_irq(0, 70000, n);
    check(16'(n > 65000 && n < 66000), 16'h0001);
    rd(tmr_pkg::ADDR_MODE, v);
    check(v, 16'h0005);
    wr(tmr_pkg::ADDR_MODE, 16'h0004);
    rd(tmr_pkg::ADDR_MODE, v);
    check(v, 16'h0004);
    wr(tmr_pkg::ADDR_MODE, 16'h0000);
    wr(tmr_pkg::ADDR_MODE, 16'h0001);
    rd(tmr_pkg::ADDR_MODE, v);
    check(v, 16'h0001);
    finish_test;
  end
endmodule // timer_event_counter_16bit_bench
